// [uvtm_pkg.sv]
// Purpose: Shared constants and types for the undervoltage fault-response block.
// Assumes: 100 MHz reference clock.
// Notes:   Field positions and codes describe the undervoltage response byte.
`default_nettype none
package uvtm_pkg;
	localparam int unsigned CLK_FREQ_HZ    = 100_000_000;
	localparam int unsigned DELAY_STEP_US  = 10;
	localparam int unsigned DELAY_STEP_CYC = DELAY_STEP_US * (CLK_FREQ_HZ / 1_000_000);
	localparam int unsigned RESP_W         = 8;
	localparam int unsigned CNT_W          = 13;
	localparam int unsigned MODE_HI        = 7;
	localparam int unsigned MODE_LO        = 6;
	localparam int unsigned RETRY_HI       = 5;
	localparam int unsigned RETRY_LO       = 3;
	localparam int unsigned DELAY_HI       = 2;
	localparam int unsigned DELAY_LO       = 0;
	localparam logic [1:0]  MODE_IGNORE    = 2'h0;
	localparam logic [1:0]  MODE_DEGLITCH  = 2'h1;
	localparam logic [1:0]  MODE_SHUTDOWN  = 2'h2;
	localparam logic [1:0]  MODE_ILLEGAL   = 2'h3;
	localparam logic [2:0]  RETRY_FOREVER  = 3'h7;
	localparam logic [7:0]  RESP_RESET     = 8'h00;
	localparam logic [7:0]  TONMAX_OFF     = 8'h00;
	localparam int unsigned SYNC_W         = 3;
	localparam int unsigned SYNC_RUN       = 0;
	localparam int unsigned SYNC_UV        = 1;
	localparam int unsigned SYNC_OC        = 2;
	typedef enum logic [1:0] {ST_RUN, ST_DEGLITCH, ST_SHUT, ST_RETRY_WAIT} uvtm_state_e;
endpackage
`default_nettype wire

// [uvtm_sync3.sv]
// Purpose: Three-stage synchroniser for pin inputs with agreement filter.
// Assumes: Inputs are asynchronous to REF_CLK_IN.
// Notes:   A change is accepted once stages two and three agree.
`default_nettype none
`timescale 1ns/100ps
module uvtm_sync3 #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_in,    // Reference clock.
	input  wire logic         srst_in,   // Synchronous reset, active high.
	input  wire logic         en_in,     // Clock enable.
	input  wire logic [W-1:0] async_in,  // Raw pin levels.
	output logic      [W-1:0] sync_out   // Filtered synchronous levels.
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s1_q     <= '0;
			s2_q     <= '0;
			s3_q     <= '0;
			sync_out <= '0;
		end else if (en_in) begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					sync_out[i] <= s3_q[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// [uvtm_uv_fault_resp.sv]
// Purpose: Undervoltage fault response and turn-on-timeout status for one channel.
// Assumes: Sequencer flags come from logic on REF_CLK_IN; run pin and comparators are pins.
// Notes:   SRST_IN stands for bias power removal and acts even while CLK_EN_IN is low.
// What this block does
// - UV fault sets VOUT summary and UV bit
// - UV or timeout fault raises alert unless masked
// - UV masked until all startup criteria hold
// - UV masked while channel inactive
// - UV masked during rise and fall ramps
// - Every response mode still sets status, alert
// - Mode 00 keeps regulating, ignores fault
// - Mode 01 runs for delay, then retry setting
// - Mode 10 disables output at once, then retry
// - Mode 11 write refused and flags CML
// - Retry 000-110 stays off until cleared
// - Retry 111 restarts forever until commanded off
// - Restart spacing from restart interval setting
// - Delay field counts 10 us steps, mode 01
// - UV bit clears on clear, cycle, bias
// - Timeout sets none-above, VOUT, timeout bits
// - Zero timeout response setting disables response
`default_nettype none
`timescale 1ns/100ps
module uvtm_uv_fault_resp
	import uvtm_pkg::*;
#(
	parameter int unsigned RETRY_W = 16
) (
	input  wire logic                        REF_CLK_IN,          // 100 MHz clock.
	input  wire logic                        SRST_IN,             // Sync reset, high.
	input  wire logic                        CLK_EN_IN,           // Freezes state when low.
	input  wire logic                        RESP_WR_IN,          // Response byte write.
	input  wire logic [uvtm_pkg::RESP_W-1:0] RESP_WDATA_IN,       // Response write data.
	output logic      [uvtm_pkg::RESP_W-1:0] RESP_RDATA_OUT,      // Response readback.
	input  wire logic [uvtm_pkg::RESP_W-1:0] TONMAX_RESP_IN,      // Timeout response setting.
	input  wire logic [RETRY_W-1:0]          RESTART_INTERVAL_IN, // Restart spacing, cycles.
	input  wire logic                        CLEAR_FAULTS_IN,     // Clear-faults pulse.
	input  wire logic                        OPERATION_ON_IN,     // Operation command on.
	input  wire logic                        CHANNEL_RUN_PIN_IN,  // Run pin, async.
	input  wire logic                        UV_CMP_IN,           // Output below UV limit.
	input  wire logic                        OC_CMP_IN,           // Overcurrent present.
	input  wire logic                        TON_MAX_REACHED_IN,  // Turn-on limit reached.
	input  wire logic                        TON_DELAY_DONE_IN,   // Turn-on delay done.
	input  wire logic                        TON_RISE_DONE_IN,    // Rise ramp done.
	input  wire logic                        TON_RISE_ACTIVE_IN,  // Rise ramp running.
	input  wire logic                        TOFF_FALL_ACTIVE_IN, // Fall ramp running.
	input  wire logic                        TON_MAX_FAULT_IN,    // Timeout fault pulse.
	input  wire logic                        ALERT_MASK_IN,       // Alert mask level.
	output logic                             OUTPUT_EN_OUT,       // Regulation enable.
	output logic                             UV_FAULT_OUT,        // UV fault status bit.
	output logic                             TON_MAX_FAULT_OUT,   // Timeout status bit.
	output logic                             VOUT_SUMMARY_OUT,    // Word VOUT summary bit.
	output logic                             NONE_ABOVE_OUT,      // Byte none-above bit.
	output logic                             CML_FAULT_OUT,       // Logic fault bit.
	output logic                             UV_MASKED_OUT,       // UV detection masked.
	output logic                             ALERT_N_OUT,         // Alert drive level.
	output logic                             ALERT_OE_N_OUT       // Alert enable, low drives.
);
	uvtm_state_e            state_q;
	logic [RESP_W-1:0]      resp_q;
	logic [CNT_W-1:0]       dly_cnt_q;
	logic [RETRY_W-1:0]     rty_cnt_q;
	logic [SYNC_W-1:0]      pins_s;
	logic                   active_q;
	logic                   armed_q;
	logic                   out_en_q;
	logic                   uv_flag_q;
	logic                   ton_flag_q;
	logic                   vout_sum_q;
	logic                   none_above_q;
	logic                   cml_q;
	logic                   alert_q;
	logic                   active;
	logic                   on_edge;
	logic                   uv_low;
	logic                   uv_mask;
	logic                   uv_event;
	logic                   ton_event;
	logic                   status_clr;
	logic                   bad_write;
	logic [1:0]             mode;
	logic [2:0]             retry;
	logic                   running;

	default clocking cb @(posedge REF_CLK_IN iff CLK_EN_IN);
	endclocking
	default disable iff (SRST_IN);

	uvtm_sync3 #(
		.W(SYNC_W)
	) u_pin_sync (
		.clk_in   (REF_CLK_IN),
		.srst_in  (SRST_IN),
		.en_in    (CLK_EN_IN),
		.async_in ({OC_CMP_IN, UV_CMP_IN, CHANNEL_RUN_PIN_IN}),
		.sync_out (pins_s)
	);

	assign active     = pins_s[SYNC_RUN] & OPERATION_ON_IN;
	assign on_edge    = active & ~active_q;
	assign uv_low     = pins_s[SYNC_UV];
	assign mode       = resp_q[MODE_HI:MODE_LO];
	assign retry      = resp_q[RETRY_HI:RETRY_LO];
	assign running    = (state_q == ST_RUN) || (state_q == ST_DEGLITCH);
	assign uv_mask    = ~armed_q | ~active | TON_RISE_ACTIVE_IN | TOFF_FALL_ACTIVE_IN
		| ~running;
	assign uv_event   = uv_low & ~uv_mask;
	assign ton_event  = TON_MAX_FAULT_IN & (TONMAX_RESP_IN != TONMAX_OFF);
	assign status_clr = CLEAR_FAULTS_IN | on_edge;
	assign bad_write  = RESP_WR_IN & (RESP_WDATA_IN[MODE_HI:MODE_LO] == MODE_ILLEGAL);

	// Response byte; an illegal mode is refused and leaves the old value.
	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			resp_q <= RESP_RESET;
		end else if (CLK_EN_IN && RESP_WR_IN && !bad_write) begin
			resp_q <= RESP_WDATA_IN;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			cml_q <= 1'b0;
		end else if (CLK_EN_IN) begin
			if (bad_write) begin
				cml_q <= 1'b1;
			end else if (CLEAR_FAULTS_IN) begin
				cml_q <= 1'b0;
			end
		end
	end

	// Startup qualification: detection arms only after every startup criterion.
	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			active_q <= 1'b0;
			armed_q  <= 1'b0;
		end else if (CLK_EN_IN) begin
			active_q <= active;
			if (!active || !running) begin
				armed_q <= 1'b0;
			end else if (TON_MAX_REACHED_IN && TON_DELAY_DONE_IN && TON_RISE_DONE_IN
				&& !uv_low && !pins_s[SYNC_OC]) begin
				armed_q <= 1'b1;
			end
		end
	end

	// Response state machine with deglitch and restart counters.
	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			state_q   <= ST_RUN;
			dly_cnt_q <= '0;
			rty_cnt_q <= '0;
		end else if (CLK_EN_IN) begin
			if (!active) begin
				state_q <= ST_RUN;
			end else begin
				unique case (state_q)
					ST_RUN: begin
						if (uv_event) begin
							unique case (mode)
								MODE_DEGLITCH: begin
									state_q   <= ST_DEGLITCH;
									dly_cnt_q <= CNT_W'(resp_q[DELAY_HI:DELAY_LO])
										* CNT_W'(DELAY_STEP_CYC);
								end
								MODE_SHUTDOWN: begin
									if (retry == RETRY_FOREVER) begin
										state_q   <= ST_RETRY_WAIT;
										rty_cnt_q <= RESTART_INTERVAL_IN;
									end else begin
										state_q <= ST_SHUT;
									end
								end
								default: state_q <= ST_RUN;
							endcase
						end
					end
					ST_DEGLITCH: begin
						if (dly_cnt_q != '0) begin
							dly_cnt_q <= dly_cnt_q - CNT_W'(1);
						end else if (uv_low && !uv_mask) begin
							if (retry == RETRY_FOREVER) begin
								state_q   <= ST_RETRY_WAIT;
								rty_cnt_q <= RESTART_INTERVAL_IN;
							end else begin
								state_q <= ST_SHUT;
							end
						end else begin
							state_q <= ST_RUN;
						end
					end
					ST_SHUT: begin
						if (CLEAR_FAULTS_IN) begin
							state_q <= ST_RUN;
						end
					end
					ST_RETRY_WAIT: begin
						if (rty_cnt_q != '0) begin
							rty_cnt_q <= rty_cnt_q - RETRY_W'(1);
						end else begin
							state_q <= ST_RUN;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			out_en_q <= 1'b0;
		end else if (CLK_EN_IN) begin
			out_en_q <= active && running
				&& !(state_q == ST_RUN && uv_event && mode == MODE_SHUTDOWN);
		end
	end

	// Status bits: a new event in the clearing cycle wins over the clear.
	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			uv_flag_q    <= 1'b0;
			ton_flag_q   <= 1'b0;
			vout_sum_q   <= 1'b0;
			none_above_q <= 1'b0;
		end else if (CLK_EN_IN) begin
			if (uv_event) begin
				uv_flag_q <= 1'b1;
			end else if (status_clr) begin
				uv_flag_q <= 1'b0;
			end
			if (ton_event) begin
				ton_flag_q   <= 1'b1;
				none_above_q <= 1'b1;
			end else if (status_clr) begin
				ton_flag_q   <= 1'b0;
				none_above_q <= 1'b0;
			end
			if (uv_event || ton_event) begin
				vout_sum_q <= 1'b1;
			end else if (status_clr) begin
				vout_sum_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (SRST_IN) begin
			alert_q <= 1'b0;
		end else if (CLK_EN_IN) begin
			if ((uv_event || ton_event) && !ALERT_MASK_IN) begin
				alert_q <= 1'b1;
			end else if (status_clr) begin
				alert_q <= 1'b0;
			end
		end
	end

	assign RESP_RDATA_OUT    = resp_q;
	assign OUTPUT_EN_OUT     = out_en_q;
	assign UV_FAULT_OUT      = uv_flag_q;
	assign TON_MAX_FAULT_OUT = ton_flag_q;
	assign VOUT_SUMMARY_OUT  = vout_sum_q;
	assign NONE_ABOVE_OUT    = none_above_q;
	assign CML_FAULT_OUT     = cml_q;
	assign UV_MASKED_OUT     = uv_mask;
	assign ALERT_N_OUT       = 1'b0;
	assign ALERT_OE_N_OUT    = ~alert_q;

	uv_status_set_a: assert property (uv_event |=> uv_flag_q && vout_sum_q)
		else $error("UV event did not set status bits");
	uv_alert_a: assert property ((uv_event && !ALERT_MASK_IN) |=> !ALERT_OE_N_OUT)
		else $error("UV event did not raise alert");
	startup_mask_a: assert property (!armed_q |-> !uv_event)
		else $error("UV detected before startup done");
	arm_criteria_a: assert property ($rose(armed_q) |-> $past(TON_MAX_REACHED_IN && TON_DELAY_DONE_IN
		&& TON_RISE_DONE_IN && !uv_low && !pins_s[SYNC_OC]))
		else $error("Detection armed before startup criteria");
	inactive_mask_a: assert property (!active |-> (uv_mask && !uv_event))
		else $error("UV detected while inactive");
	ramp_mask_a: assert property ((TON_RISE_ACTIVE_IN || TOFF_FALL_ACTIVE_IN) |-> !uv_event)
		else $error("UV detected during ramp");
	ignore_mode_a: assert property ((state_q == ST_RUN && uv_event && mode == MODE_IGNORE
		&& active) |=> state_q == ST_RUN)
		else $error("Ignore mode left run state");
	shut_now_a: assert property ((state_q == ST_RUN && uv_event && mode == MODE_SHUTDOWN)
		|=> !OUTPUT_EN_OUT)
		else $error("Shutdown mode kept output on");
	cml_refuse_a: assert property (bad_write |=> cml_q && resp_q == $past(resp_q))
		else $error("Illegal mode write not refused");
	shut_hold_a: assert property ((state_q == ST_SHUT && active && !CLEAR_FAULTS_IN)
		|=> state_q == ST_SHUT)
		else $error("Shut state left without clear");
	retry_space_a: assert property ((state_q == ST_RETRY_WAIT && active && rty_cnt_q != '0)
		|=> state_q == ST_RETRY_WAIT)
		else $error("Restart came before interval");
	deglitch_load_a: assert property ((state_q == ST_RUN && uv_event && mode == MODE_DEGLITCH
		&& active) |=> dly_cnt_q == CNT_W'($past(resp_q[DELAY_HI:DELAY_LO])) * CNT_W'(DELAY_STEP_CYC))
		else $error("Deglitch delay loaded wrong");
	uv_hold_a: assert property ((uv_flag_q && !status_clr) |=> uv_flag_q)
		else $error("UV bit cleared without cause");
	ton_status_a: assert property (ton_event |=> ton_flag_q && none_above_q && vout_sum_q)
		else $error("Timeout status bits not set");
	ton_zero_a: assert property ((TON_MAX_FAULT_IN && TONMAX_RESP_IN == TONMAX_OFF
		&& !ton_flag_q) |=> !ton_flag_q)
		else $error("Zero timeout setting still responded");
	resample_a: assert property ((state_q == ST_DEGLITCH && active && dly_cnt_q == '0 && !uv_low)
		|=> state_q == ST_RUN)
		else $error("Deglitch did not resume on clean sample");

	deglitch_pass_c: cover property (state_q == ST_DEGLITCH ##1 state_q == ST_RUN);
	retry_loop_c: cover property (state_q == ST_RETRY_WAIT ##1 state_q == ST_RUN);
	shut_clear_c: cover property (state_q == ST_SHUT ##1 state_q == ST_RUN);
	cml_c: cover property (bad_write);
endmodule
`default_nettype wire

// [uvtm_host_model.sv]
// Purpose: Host-side model that writes the response byte, sets the timeout setting and clears.
// Assumes: Calls start 1 ns after a rising clock edge.
// Notes:   The alert wire has a pull-up, so the block can only pull it low.
`timescale 1ns/100ps
`default_nettype none
module uvtm_host_model (
	input  wire logic       clk_in,         // Reference clock.
	input  wire logic       alert_n_in,     // Block alert drive level.
	input  wire logic       alert_oe_n_in,  // Block alert enable, low drives.
	output logic            alert_line_out, // Resolved alert wire.
	output logic            wr_out,         // Response byte write.
	output logic      [7:0] wdata_out,      // Response write data.
	output logic      [7:0] tonmax_out,     // Timeout response setting.
	output logic            clear_out       // Clear-faults pulse.
);
	assign alert_line_out = alert_oe_n_in ? 1'b1 : alert_n_in;
	initial begin
		wr_out = 1'b0;
		wdata_out = 8'h00;
		tonmax_out = 8'h80;
		clear_out = 1'b0;
	end
	// Mode 11 goes out only when a scenario asks for the refusal.
	task automatic write_resp(input logic [7:0] d);
		wr_out = 1'b1;
		wdata_out = d;
		@(posedge clk_in);
		#1;
		wr_out = 1'b0;
		wdata_out = ~d;
		// One idle edge keeps back-to-back calls from re-raising the strobe at once.
		@(posedge clk_in);
		#1;
	endtask
	task automatic clear();
		clear_out = 1'b1;
		@(posedge clk_in);
		#1;
		clear_out = 1'b0;
		@(posedge clk_in);
		#1;
	endtask
	// A zero setting is sent only when a scenario asks for it.
	task automatic set_tonmax(input logic [7:0] d);
		tonmax_out = d;
	endtask
endmodule
`default_nettype wire

// [testbench.sv]
// Purpose: Self-checking bench for the undervoltage fault-response block.
// Assumes: Inputs change 1 ns after the rising edge; synchronisers take 4 cycles.
// Notes:   Delay field 1 gives 1000 cycles of continued operation.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import uvtm_pkg::*;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        clk_en = 1'b1;
	logic [15:0] restart = 16'h0004;
	logic        run_pin = 1'b0;
	logic        op_on = 1'b0;
	logic        uv = 1'b0;
	logic        oc = 1'b0;
	logic        t_max = 1'b0;
	logic        t_dly = 1'b0;
	logic        t_rise = 1'b0;
	logic        rise_act = 1'b0;
	logic        fall_act = 1'b0;
	logic        t_flt = 1'b0;
	logic        mask = 1'b0;
	logic        wr, clr, out_en, uv_flt, tm_flt, vsum, none_ab, cml, uv_msk, al_n, al_oe_n, al;
	logic [7:0]  wdata, rdata, tm_resp;
	int          err_count = 0;
	int          checks = 0;
	always #5 clk = ~clk;
	uvtm_uv_fault_resp #(.RETRY_W(16)) dut_u (.REF_CLK_IN(clk), .SRST_IN(srst),
		.CLK_EN_IN(clk_en), .RESP_WR_IN(wr), .RESP_WDATA_IN(wdata), .RESP_RDATA_OUT(rdata),
		.TONMAX_RESP_IN(tm_resp), .RESTART_INTERVAL_IN(restart), .CLEAR_FAULTS_IN(clr),
		.OPERATION_ON_IN(op_on), .CHANNEL_RUN_PIN_IN(run_pin), .UV_CMP_IN(uv), .OC_CMP_IN(oc),
		.TON_MAX_REACHED_IN(t_max), .TON_DELAY_DONE_IN(t_dly), .TON_RISE_DONE_IN(t_rise),
		.TON_RISE_ACTIVE_IN(rise_act), .TOFF_FALL_ACTIVE_IN(fall_act),
		.TON_MAX_FAULT_IN(t_flt), .ALERT_MASK_IN(mask), .OUTPUT_EN_OUT(out_en),
		.UV_FAULT_OUT(uv_flt), .TON_MAX_FAULT_OUT(tm_flt), .VOUT_SUMMARY_OUT(vsum),
		.NONE_ABOVE_OUT(none_ab), .CML_FAULT_OUT(cml), .UV_MASKED_OUT(uv_msk),
		.ALERT_N_OUT(al_n), .ALERT_OE_N_OUT(al_oe_n));
	uvtm_host_model host_u (.clk_in(clk), .alert_n_in(al_n), .alert_oe_n_in(al_oe_n),
		.alert_line_out(al), .wr_out(wr), .wdata_out(wdata), .tonmax_out(tm_resp),
		.clear_out(clr));
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic bring_up();
		{run_pin, op_on, t_max, t_dly, t_rise} = 5'h1f;
		{uv, oc, rise_act, fall_act} = 4'h0;
		step(10);
	endtask
	task automatic uv_hit();
		uv = 1'b1;
		step(8);
	endtask
	task automatic t_reset();
		chk("reset flags", 8'h03, {out_en, uv_flt, tm_flt, vsum, none_ab, cml, uv_msk, al_oe_n});
		chk("reset byte", 8'h00, rdata);
		$display("test reset done");
	endtask
	task automatic t_write();
		host_u.write_resp(8'h41);
		chk("byte", 8'h41, rdata);
		host_u.write_resp(8'hc1);
		chk("refused", 8'h41, rdata);
		chk("cml", 8'h01, cml);
		host_u.clear();
		chk("cml cleared", 8'h00, cml);
		$display("test write done");
	endtask
	task automatic t_mask();
		host_u.write_resp(8'h80);
		{run_pin, op_on, oc} = 3'b111;
		step(10);
		uv_hit();
		chk("startup mask", 8'h01, {uv_flt, uv_msk});
		{uv, t_max, t_dly, t_rise} = 4'h7;
		step(10);
		uv_hit();
		chk("overcurrent mask", 8'h01, {uv_flt, uv_msk});
		{uv, oc} = 2'b00;
		step(10);
		chk("armed mask", 8'h00, uv_msk);
		rise_act = 1'b1;
		uv_hit();
		chk("rise mask", 8'h01, {uv_flt, uv_msk});
		uv = 1'b0;
		step(6);
		{rise_act, fall_act} = 2'b01;
		uv_hit();
		chk("fall mask", 8'h01, {uv_flt, uv_msk});
		{uv, fall_act, op_on} = 3'b000;
		step(10);
		uv_hit();
		chk("inactive mask", 8'h00, uv_flt);
		$display("test mask done");
	endtask
	task automatic t_shut();
		bring_up();
		chk("armed", 8'h02, {out_en, uv_msk});
		uv_hit();
		chk("shut", 8'h06, {out_en, uv_flt, vsum, al});
		uv = 1'b0;
		step(20);
		chk("stays off", 8'h00, out_en);
		host_u.clear();
		step(2);
		chk("cleared", 8'h03, {uv_flt, vsum, al, out_en});
		$display("test shut done");
	endtask
	task automatic t_ignore();
		host_u.write_resp(8'h00);
		mask = 1'b1;
		step(10);
		uv_hit();
		chk("ignore", 8'h07, {out_en, uv_flt, al});
		uv = 1'b0;
		step(6);
		mask = 1'b0;
		host_u.clear();
		$display("test ignore done");
	endtask
	task automatic t_deglitch();
		host_u.write_resp(8'h49);
		step(10);
		uv_hit();
		step(900);
		chk("delay run", 8'h03, {out_en, uv_flt});
		step(150);
		chk("delay off", 8'h00, out_en);
		uv = 1'b0;
		host_u.clear();
		step(10);
		uv_hit();
		uv = 1'b0;
		step(1100);
		chk("recovered", 8'h01, out_en);
		host_u.clear();
		$display("test deglitch done");
	endtask
	task automatic t_retry();
		restart = 16'h0008;
		host_u.write_resp(8'hb8);
		step(10);
		uv = 1'b1;
		for (int i = 0; i < 20 && out_en !== 1'b0; i++) begin
			step(1);
		end
		step(7);
		chk("retry wait", 8'h00, out_en);
		step(4);
		chk("restarted", 8'h01, out_en);
		uv = 1'b0;
		host_u.clear();
		$display("test retry done");
	endtask
	task automatic t_timeout();
		host_u.set_tonmax(8'h00);
		t_flt = 1'b1;
		step(1);
		t_flt = 1'b0;
		step(1);
		chk("tmo off", 8'h01, {tm_flt, none_ab, vsum, al});
		host_u.set_tonmax(8'h80);
		t_flt = 1'b1;
		step(1);
		t_flt = 1'b0;
		step(1);
		chk("tmo", 8'h0e, {tm_flt, none_ab, vsum, al});
		op_on = 1'b0;
		step(5);
		op_on = 1'b1;
		step(3);
		chk("cycled", 8'h01, {tm_flt, none_ab, vsum, al});
		t_flt = 1'b1;
		step(1);
		t_flt = 1'b0;
		srst = 1'b1;
		step(2);
		srst = 1'b0;
		chk("bias flags", 8'h03, {out_en, uv_flt, tm_flt, vsum, none_ab, cml, uv_msk, al_oe_n});
		chk("bias byte", 8'h00, rdata);
		$display("test timeout done");
	endtask
	task automatic t_freeze();
		clk_en = 1'b0;
		host_u.write_resp(8'h41);
		t_flt = 1'b1;
		step(1);
		{t_flt, clk_en} = 2'b01;
		chk("frozen byte", 8'hb8, rdata);
		chk("frozen flag", 8'h00, tm_flt);
		$display("test freeze done");
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#1;
		srst = 1'b0;
		t_reset();
		t_write();
		t_mask();
		t_shut();
		t_ignore();
		t_deglitch();
		t_retry();
		t_freeze();
		t_timeout();
		give_verdict();
	end
	// Cuts a hang short; the tests need about 2500 cycles.
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
